// file: cms_mode_reg.sv
// Purpose: Comparator mode select register with edge interrupt enables.
// Assumes: Core writes take effect on the clock edge of the write strobe.
// Notes:   Read data is registered and valid one cycle after the address.
`timescale 1ns/1ps
// How it works
// - Bits 7, 6, 3 and 2 always read zero; writes there are dropped.
// - Bit 5 enables rising-edge interrupt requests when set.
// - Bit 4 enables falling-edge interrupt requests when set.
// - Bits 1-0 pick response time: 0 fastest, 3 lowest power.
module cms_mode_reg
   import cms_pkg::*;
(
   input  wire logic               i_clock,
   input  wire logic               i_resetn,
   input  wire cms_sfr_req_t       i_sfr,
   input  wire cms_edges_t         i_edges,
   output logic [7:0]              o_rdata,
   output logic [CMS_SEL_W-1:0]    o_response_sel,
   output logic                    o_rise_irq,
   output logic                    o_fall_irq
);

   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic [7:0] rdata_q;
   logic       hit;

   assign hit = (i_sfr.addr == CMS_ADDR);

   always_comb begin
      mode_d = mode_q;
      if (i_sfr.wr && hit) begin
         mode_d = i_sfr.wdata & CMS_WRITE_MASK;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         mode_q <= CMS_RESET;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= hit ? (mode_q & CMS_WRITE_MASK) : 8'h00;
      end
   end

   assign o_rdata = rdata_q;

   assign o_response_sel = mode_q[CMS_SEL_LSB +: CMS_SEL_W];

   cms_irq_gate u_rise (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_event   (i_edges.rise),
      .i_enable  (mode_q[CMS_RISE_BIT]),
      .o_request (o_rise_irq)
   );

   cms_irq_gate u_fall (
      .i_clock   (i_clock),
      .i_resetn  (i_resetn),
      .i_event   (i_edges.fall),
      .i_enable  (mode_q[CMS_FALL_BIT]),
      .o_request (o_fall_irq)
   );

   property p_unused_zero;
      @(posedge i_clock) disable iff (!i_resetn)
         (o_rdata & ~CMS_WRITE_MASK) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("Unused bits read non-zero.");

   property p_rise_off;
      @(posedge i_clock) disable iff (!i_resetn)
         !mode_q[CMS_RISE_BIT] ##1 !mode_q[CMS_RISE_BIT] |-> !o_rise_irq;
   endproperty
   a_rise_off: assert property (p_rise_off) else $error("Rising request while disabled.");

   property p_rise_on;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_edges.rise && mode_q[CMS_RISE_BIT]) |=> o_rise_irq;
   endproperty
   a_rise_on: assert property (p_rise_on) else $error("Enabled rising edge not requested.");

   property p_fall_off;
      @(posedge i_clock) disable iff (!i_resetn)
         !mode_q[CMS_FALL_BIT] ##1 !mode_q[CMS_FALL_BIT] |-> !o_fall_irq;
   endproperty
   a_fall_off: assert property (p_fall_off) else $error("Falling request while disabled.");

   property p_fall_on;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_edges.fall && mode_q[CMS_FALL_BIT]) |=> o_fall_irq;
   endproperty
   a_fall_on: assert property (p_fall_on) else $error("Enabled falling edge not requested.");

   property p_sel_write;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_sfr.wr && hit) |=> o_response_sel == $past(i_sfr.wdata[1:0]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("Mode field did not take written value.");

   property p_sel_hold;
      @(posedge i_clock) disable iff (!i_resetn)
         !(i_sfr.wr && hit) |=> $stable(o_response_sel);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("Mode field changed without a write.");

   property p_readback;
      @(posedge i_clock) disable iff (!i_resetn)
         hit |=> o_rdata[1:0] == $past(o_response_sel);
   endproperty
   a_readback: assert property (p_readback) else $error("Read data does not match mode field.");

   property p_mode_unused;
      @(posedge i_clock) disable iff (!i_resetn)
         (mode_q & ~CMS_WRITE_MASK) == 8'h00;
   endproperty
   a_mode_unused: assert property (p_mode_unused) else $error("Stored unused bits non-zero.");

   property p_miss_zero;
      @(posedge i_clock) disable iff (!i_resetn)
         !hit |=> o_rdata == 8'h00;
   endproperty
   a_miss_zero: assert property (p_miss_zero) else $error("Read data non-zero for another address.");

   property p_old_read;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_sfr.wr && hit) |=> o_rdata == ($past(mode_q) & CMS_WRITE_MASK);
   endproperty
   a_old_read: assert property (p_old_read) else $error("Read during write did not return old value.");

   property p_rise_write;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_sfr.wr && hit) |=> mode_q[CMS_RISE_BIT] == $past(i_sfr.wdata[CMS_RISE_BIT]);
   endproperty
   a_rise_write: assert property (p_rise_write) else $error("Rising enable write lost.");

   property p_rise_keep;
      @(posedge i_clock) disable iff (!i_resetn)
         !(i_sfr.wr && hit) |=> $stable(mode_q[CMS_RISE_BIT]);
   endproperty
   a_rise_keep: assert property (p_rise_keep) else $error("Rising enable changed without a write.");

   property p_rise_read;
      @(posedge i_clock) disable iff (!i_resetn)
         hit |=> o_rdata[CMS_RISE_BIT] == $past(mode_q[CMS_RISE_BIT]);
   endproperty
   a_rise_read: assert property (p_rise_read) else $error("Rising enable read back wrong.");

   property p_fall_write;
      @(posedge i_clock) disable iff (!i_resetn)
         (i_sfr.wr && hit) |=> mode_q[CMS_FALL_BIT] == $past(i_sfr.wdata[CMS_FALL_BIT]);
   endproperty
   a_fall_write: assert property (p_fall_write) else $error("Falling enable write lost.");

   property p_fall_keep;
      @(posedge i_clock) disable iff (!i_resetn)
         !(i_sfr.wr && hit) |=> $stable(mode_q[CMS_FALL_BIT]);
   endproperty
   a_fall_keep: assert property (p_fall_keep) else $error("Falling enable changed without a write.");

   property p_fall_read;
      @(posedge i_clock) disable iff (!i_resetn)
         hit |=> o_rdata[CMS_FALL_BIT] == $past(mode_q[CMS_FALL_BIT]);
   endproperty
   a_fall_read: assert property (p_fall_read) else $error("Falling enable read back wrong.");

   property p_rise_quiet;
      @(posedge i_clock) disable iff (!i_resetn)
         !i_edges.rise |=> !o_rise_irq;
   endproperty
   a_rise_quiet: assert property (p_rise_quiet) else $error("Rising request without an event.");

   property p_fall_quiet;
      @(posedge i_clock) disable iff (!i_resetn)
         !i_edges.fall |=> !o_fall_irq;
   endproperty
   a_fall_quiet: assert property (p_fall_quiet) else $error("Falling request without an event.");

   property p_rise_match;
      @(posedge i_clock) disable iff (!i_resetn)
         1'b1 |=> o_rise_irq == $past(i_edges.rise && mode_q[CMS_RISE_BIT]);
   endproperty
   a_rise_match: assert property (p_rise_match) else $error("Rising request not event and enable.");

   property p_fall_match;
      @(posedge i_clock) disable iff (!i_resetn)
         1'b1 |=> o_fall_irq == $past(i_edges.fall && mode_q[CMS_FALL_BIT]);
   endproperty
   a_fall_match: assert property (p_fall_match) else $error("Falling request not event and enable.");

   property p_reset_state;
      @(posedge i_clock)
         !i_resetn |=> (mode_q == CMS_RESET) && (o_rdata == 8'h00) && !o_rise_irq && !o_fall_irq;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("Outputs not at reset values.");

endmodule : cms_mode_reg

// file: cms_pkg.sv
// Purpose: Shared constants and types for the comparator mode register block.
// Assumes: Registers sit in an 8-bit special-function-register space.
// Notes:   Bit positions and the reset value are fixed by the register layout.
package cms_pkg;

   localparam logic [7:0] CMS_ADDR       = 8'h9D;
   localparam logic [7:0] CMS_RESET      = 8'h02;
   localparam int         CMS_RISE_BIT   = 5;
   localparam int         CMS_FALL_BIT   = 4;
   localparam int         CMS_SEL_LSB    = 0;
   localparam int         CMS_SEL_W      = 2;
   localparam logic [7:0] CMS_WRITE_MASK = 8'h33;

   // Special-function-register access from the core.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } cms_sfr_req_t;

   // Edge events reported by the comparator.
   typedef struct packed {
      logic rise;
      logic fall;
   } cms_edges_t;

endpackage : cms_pkg

// file: cms_irq_gate.sv
// Purpose: Gates one comparator edge event with its enable bit.
// Assumes: Event and enable are synchronous to i_clock.
// Notes:   Request is registered so it stays a clean flip-flop output.
`timescale 1ns/1ps
module cms_irq_gate
   import cms_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_resetn,
   input  wire logic i_event,
   input  wire logic i_enable,
   output logic      o_request
);

   logic request_q;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         request_q <= 1'b0;
      end else begin
         request_q <= i_event & i_enable;
      end
   end

   assign o_request = request_q;

   property p_gate;
      @(posedge i_clock) disable iff (!i_resetn)
         !i_enable |=> !o_request;
   endproperty
   a_gate: assert property (p_gate) else $error("Request raised while its enable was clear.");

endmodule : cms_irq_gate

// file: cms_mode_reg_tb.sv
// Purpose: Self-checking bench for the comparator mode register.
// Assumes: Inputs change 1 ns after the rising edge; outputs settle by then.
// Notes:   A reference copy of the register predicts every output each cycle.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module cms_mode_reg_tb
   import cms_pkg::*;
();
   logic                 i_clock;
   logic                 i_resetn;
   cms_sfr_req_t         sfr;
   cms_edges_t           edges;
   logic [7:0]           rdata;
   logic [CMS_SEL_W-1:0] sel;
   logic                 rise_irq;
   logic                 fall_irq;
   logic [7:0]           e_reg;
   logic [7:0]           e_rd;
   logic [7:0]           vals [7] = '{8'hFF, 8'hCC, 8'h00, 8'h33, 8'h01, 8'h02, 8'h03};
   int                   fails = 0;
   int                   samples_checked = 0;

   cms_mode_reg uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_sfr(sfr), .i_edges(edges),
      .o_rdata(rdata), .o_response_sel(sel), .o_rise_irq(rise_irq), .o_fall_irq(fall_irq));

   always #50 i_clock = ~i_clock;

   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // Register value after one cycle of bus inputs.
   function automatic logic [7:0] exp_next(input logic [7:0] cur, input logic [7:0] a, input logic [7:0] d,
                                           input logic w);
      return (w && a == CMS_ADDR) ? (d & CMS_WRITE_MASK) : cur;
   endfunction : exp_next

   // Read data expected one cycle after the address was shown.
   function automatic logic [7:0] exp_read(input logic [7:0] cur, input logic [7:0] a);
      return (a == CMS_ADDR) ? (cur & CMS_WRITE_MASK) : 8'h00;
   endfunction : exp_read

   // Applies one cycle of inputs, then predicts and compares the outputs.
   task automatic step(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
                       input logic f);
      sfr = '{addr: a, wdata: d, wr: w};
      edges = '{rise: r, fall: f};
      @(posedge i_clock);
      #1;
      e_rd = exp_read(e_reg, a);
      `CHK("rdata", e_rd, rdata)
      `CHK("rise_irq", r & e_reg[CMS_RISE_BIT], rise_irq)
      `CHK("fall_irq", f & e_reg[CMS_FALL_BIT], fall_irq)
      e_reg = exp_next(e_reg, a, d, w);
      `CHK("response_sel", e_reg[1:0], sel)
   endtask : step

   task automatic do_reset(input int n);
      i_resetn = 1'b0;
      sfr = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0};
      edges = '{rise: 1'b1, fall: 1'b1};
      repeat (n) @(posedge i_clock);
      #1;
      e_reg = CMS_RESET;
      `CHK("rst_sel", CMS_RESET[1:0], sel)
      `CHK("rst_irq", 2'h0, {rise_irq, fall_irq})
      `CHK("rst_rdata", 8'h00, rdata)
      i_resetn = 1'b1;
   endtask : do_reset

   initial begin
      i_clock = 1'b0;
      void'($urandom(77));
      do_reset(20);
      step(8'h9D, 8'h00, 1'b0, 1'b0, 1'b0);
      foreach (vals[i]) begin
         step(8'h9D, vals[i], 1'b1, 1'b1, 1'b1);
         step(8'h9D, ~vals[i], 1'b0, 1'b1, 1'b1);
         step(8'h9E, 8'hFF, 1'b1, 1'b1, 1'b0);
      end
      do_reset(2);
      repeat (400) begin
         step(($urandom % 4 == 0) ? 8'($urandom) : 8'h9D, 8'($urandom), 1'($urandom),
              1'($urandom), 1'($urandom));
      end
      wrap_up();
   end
endmodule : cms_mode_reg_tb
